// *** core/piolc_top.sv ***
/*
 Parallel I/O line controller: Avalon-MM register slave, pin output muxing,
 pull-up, open-drain and masked synchronous output for up to 32 lines.
 Assumes pin levels and peripheral signals are synchronous to clk, and that
 clk_enable comes from the power manager and gates pin sampling and irq.
*/
`timescale 1ns/1ps
`include "piolc_defs.svh"

// Notes on behaviour
// - Pull-up enable write clears status bit, disable write sets it, always.
// - Pull-up status reads 1 when disabled, 0 when enabled.
// - Pull-up status resets to zero, all pull-ups on.
// - Ownership reads 1 for controller, 0 for peripheral; enable sets, disable clears.
// - Lines without peripheral ignore ownership writes and always read 1.
// - Ownership reset value is a parameter, normally all ones.
// - A-select clears selection bit, B-select sets it; 0 is A, 1 is B.
// - Selection steers only output paths; both peripheral inputs see the pin.
// - Selection status resets to zero, peripheral A everywhere.
// - Under peripheral ownership the selected peripheral drives enable and level.
// - Output enable sets, disable clears; 1 drives the line under controller.
// - Set and clear writes change output level bits that drive enabled lines.
// - Output enable and level update even while a peripheral owns the line.
// - Direct level write changes only bits whose mask bit is set.
// - Mask enable sets, mask disable clears, visible in mask status.
// - Mask status resets to zero, direct writes disabled.
// - Open-drain lines are only pulled low or released, never driven high.
// - Open-drain enable sets, disable clears, regardless of ownership.
// - Open-drain status resets to zero.
// - Configuration writes work without controller clock; pin reads need it.
// - Interrupt output asserts only with clock enabled; clock off after reset.
// - Pin level register returns the line level sampled while the clock is enabled and holds it while disabled.
module piolc_top
   import piolc_pkg::*;
#(
   parameter logic [31:0] MUX_LINES = 32'hFFFF_FFFF,
   parameter logic [31:0] OWN_RESET = 32'hFFFF_FFFF
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_enable,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [31:0] pin_in,
   output logic      [31:0] pin_out,
   output logic      [31:0] pin_oe,
   output logic      [31:0] pullup_on,
   input  wire logic [31:0] periph_a_out,
   input  wire logic [31:0] periph_a_oe,
   input  wire logic [31:0] periph_b_out,
   input  wire logic [31:0] periph_b_oe,
   output logic      [31:0] periph_a_in,
   output logic      [31:0] periph_b_in,
   input  wire logic        line_irq_in,
   output logic             irq
);

   // ************************************************************
   // State
   // ************************************************************
   piolc_state_s state_reg;
   piolc_state_s state_next;
   logic [31:0]  wmask;
   logic [31:0]  own_view;
   logic [31:0]  drv_en;
   logic [31:0]  drv_lvl;

   // Expands byte enables so a partial-word write acts only on its lanes.
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // Bitwise set/clear update shared by every register triplet.
   function automatic logic [31:0] set_clr(input logic [31:0] cur,
                                           input logic [31:0] set_bits,
                                           input logic [31:0] clr_bits);
      set_clr = (cur | set_bits) & ~clr_bits;
   endfunction

   assign wmask    = avs_writedata & lane_mask(avs_byteenable);
   assign own_view = state_reg.own | ~MUX_LINES;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic hit;
      logic [31:0] rd;
      // Writes commit only on the waitrequest-low edge, so a held request lands once.
      hit = avs_write && state_reg.bus == PIOLC_RESP;
      rd  = `PIOLC_RST_ZERO;
      state_next = state_reg;
      state_next.clk_run = clk_enable;
      if (clk_enable) begin
         state_next.pin_smp = pin_in;
      end
      if (hit) begin
         case (avs_address)
            `PIOLC_OFF_OWN_EN: state_next.own =
               set_clr(state_reg.own, wmask & MUX_LINES, '0);
            `PIOLC_OFF_OWN_DIS: state_next.own =
               set_clr(state_reg.own, '0, wmask & MUX_LINES);
            `PIOLC_OFF_OUT_EN: state_next.out_en =
               set_clr(state_reg.out_en, wmask, '0);
            `PIOLC_OFF_OUT_DIS: state_next.out_en =
               set_clr(state_reg.out_en, '0, wmask);
            `PIOLC_OFF_LVL_SET: state_next.lvl =
               set_clr(state_reg.lvl, wmask, '0);
            `PIOLC_OFF_LVL_CLR: state_next.lvl =
               set_clr(state_reg.lvl, '0, wmask);
            `PIOLC_OFF_LVL: state_next.lvl =
               (state_reg.lvl & ~(state_reg.mask & lane_mask(avs_byteenable)))
               | (avs_writedata & state_reg.mask
                  & lane_mask(avs_byteenable));
            `PIOLC_OFF_OD_EN: state_next.od =
               set_clr(state_reg.od, wmask, '0);
            `PIOLC_OFF_OD_DIS: state_next.od =
               set_clr(state_reg.od, '0, wmask);
            `PIOLC_OFF_PU_EN: state_next.pu_off =
               set_clr(state_reg.pu_off, '0, wmask);
            `PIOLC_OFF_PU_DIS: state_next.pu_off =
               set_clr(state_reg.pu_off, wmask, '0);
            `PIOLC_OFF_SEL_A: state_next.sel_b =
               set_clr(state_reg.sel_b, '0, wmask);
            `PIOLC_OFF_SEL_B: state_next.sel_b =
               set_clr(state_reg.sel_b, wmask, '0);
            `PIOLC_OFF_MASK_EN: state_next.mask =
               set_clr(state_reg.mask, wmask, '0);
            `PIOLC_OFF_MASK_DIS: state_next.mask =
               set_clr(state_reg.mask, '0, wmask);
            default: begin
            end
         endcase
      end
      case (avs_address)
         `PIOLC_OFF_OWN_STAT:  rd = own_view;
         `PIOLC_OFF_OUT_STAT:  rd = state_reg.out_en;
         `PIOLC_OFF_LVL:       rd = state_reg.lvl;
         `PIOLC_OFF_PIN:       rd = state_reg.pin_smp;
         `PIOLC_OFF_OD_STAT:   rd = state_reg.od;
         `PIOLC_OFF_PU_STAT:   rd = state_reg.pu_off;
         `PIOLC_OFF_SEL_STAT:  rd = state_reg.sel_b;
         `PIOLC_OFF_MASK_STAT: rd = state_reg.mask;
         default:              rd = `PIOLC_RST_ZERO;
      endcase
      // Every access takes one wait cycle, so read data is always registered.
      case (state_reg.bus)
         PIOLC_IDLE: begin
            if (avs_read || avs_write) begin
               state_next.bus   = PIOLC_RESP;
               state_next.rdata = avs_read ? rd : `PIOLC_RST_ZERO;
            end
         end
         PIOLC_RESP: state_next.bus = PIOLC_IDLE;
         default:    state_next.bus = PIOLC_IDLE;
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.bus     <= PIOLC_IDLE;
         state_reg.rdata   <= `PIOLC_RST_ZERO;
         state_reg.own     <= OWN_RESET;
         state_reg.sel_b   <= `PIOLC_RST_ZERO;
         state_reg.out_en  <= `PIOLC_RST_ZERO;
         state_reg.lvl     <= `PIOLC_RST_ZERO;
         state_reg.mask    <= `PIOLC_RST_ZERO;
         state_reg.od      <= `PIOLC_RST_ZERO;
         state_reg.pu_off  <= `PIOLC_RST_ZERO;
         state_reg.pin_smp <= `PIOLC_RST_ZERO;
         state_reg.clk_run <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Pin muxing
   // ************************************************************
   for (genvar i = 0; i < `PIOLC_LINES; i++) begin : g_line
      // A peripheral's drive choice reaches the pin only once the controller lets go.
      assign drv_en[i]  = own_view[i] ? state_reg.out_en[i]
                        : state_reg.sel_b[i] ? periph_b_oe[i] : periph_a_oe[i];
      assign drv_lvl[i] = own_view[i] ? state_reg.lvl[i]
                        : state_reg.sel_b[i] ? periph_b_out[i] : periph_a_out[i];
   end

   // Open drain releases the line instead of driving a high level.
   assign pin_oe  = drv_en & ~(state_reg.od & drv_lvl);
   assign pin_out = drv_lvl & ~state_reg.od;

   assign pullup_on       = ~state_reg.pu_off;
   assign periph_a_in     = pin_in;
   assign periph_b_in     = pin_in;
   assign avs_readdata    = state_reg.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && state_reg.bus == PIOLC_IDLE;
   assign irq             = line_irq_in & state_reg.clk_run;

endmodule

// *** core/piolc_defs.svh ***
/*
 Register offsets, reset values and widths for the parallel I/O line controller.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef PIOLC_DEFS_SVH
`define PIOLC_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define PIOLC_OFF_OWN_EN      8'h00
`define PIOLC_OFF_OWN_DIS     8'h04
`define PIOLC_OFF_OWN_STAT    8'h08
`define PIOLC_OFF_OUT_EN      8'h10
`define PIOLC_OFF_OUT_DIS     8'h14
`define PIOLC_OFF_OUT_STAT    8'h18
`define PIOLC_OFF_LVL_SET     8'h30
`define PIOLC_OFF_LVL_CLR     8'h34
`define PIOLC_OFF_LVL         8'h38
`define PIOLC_OFF_PIN         8'h3C
`define PIOLC_OFF_OD_EN       8'h50
`define PIOLC_OFF_OD_DIS      8'h54
`define PIOLC_OFF_OD_STAT     8'h58
`define PIOLC_OFF_PU_DIS      8'h60
`define PIOLC_OFF_PU_EN       8'h64
`define PIOLC_OFF_PU_STAT     8'h68
`define PIOLC_OFF_SEL_A       8'h70
`define PIOLC_OFF_SEL_B       8'h74
`define PIOLC_OFF_SEL_STAT    8'h78
`define PIOLC_OFF_MASK_EN     8'hA0
`define PIOLC_OFF_MASK_DIS    8'hA4
`define PIOLC_OFF_MASK_STAT   8'hA8

// ************************************************************
// Reset values and widths
// ************************************************************
`define PIOLC_RST_ZERO        32'h0000_0000
`define PIOLC_RST_ONES        32'hFFFF_FFFF
`define PIOLC_ADDR_W          8
`define PIOLC_LINES           32

`endif

// *** core/piolc_pkg.sv ***
/*
 Types shared by the parallel I/O line controller.
 Assumes the defs header is on the include path.
*/
`include "piolc_defs.svh"

package piolc_pkg;
   typedef logic [`PIOLC_LINES-1:0] piolc_word_t;

   typedef enum logic {
      PIOLC_IDLE,
      PIOLC_RESP
   } piolc_bus_e;

   typedef struct packed {
      piolc_bus_e  bus;
      piolc_word_t rdata;
      piolc_word_t own;
      piolc_word_t sel_b;
      piolc_word_t out_en;
      piolc_word_t lvl;
      piolc_word_t mask;
      piolc_word_t od;
      piolc_word_t pu_off;
      piolc_word_t pin_smp;
      logic        clk_run;
   } piolc_state_s;
endpackage

// *** testbench/piolc_assertions.sv ***
/* Port checker for the parallel I/O line controller.
   Assumes binding to piolc_top with one clock and a synchronous reset. */
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module piolc_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        clk_enable,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pullup_on,
   input wire logic [31:0] periph_a_in,
   input wire logic [31:0] periph_b_in,
   input wire logic        line_irq_in,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_go;
   assign wr_go = avs_write && !avs_waitrequest && (avs_byteenable == 4'hF);
   property p_pu_en; wr_go && avs_address == 8'h64 |=>
      (pullup_on & $past(avs_writedata)) == $past(avs_writedata); endproperty
   a_pu_en: assert property (p_pu_en) else $error("pull-up enable write missed");
   property p_pu_dis; wr_go && avs_address == 8'h60 |=>
      (pullup_on & $past(avs_writedata)) == 32'h0000_0000; endproperty
   a_pu_dis: assert property (p_pu_dis) else $error("pull-up disable write missed");
   property p_pu_keep; wr_go && avs_address == 8'h64 |=>
      ((pullup_on ^ $past(pullup_on)) & ~$past(avs_writedata)) == 32'h0000_0000; endproperty
   a_pu_keep: assert property (p_pu_keep) else $error("zero bits changed a pull-up");
   property p_pu_rst; $fell(rst) |-> pullup_on == 32'hFFFF_FFFF; endproperty
   a_pu_rst: assert property (p_pu_rst) else $error("pull-ups not on after reset");
   property p_in_fwd; periph_a_in == pin_in && periph_b_in == pin_in; endproperty
   a_in_fwd: assert property (p_in_fwd) else $error("peripheral input not the pin");
   property p_irq_gate; irq |-> line_irq_in && $past(clk_enable); endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without clock");
   property p_irq_rst; $fell(rst) |-> !irq; endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
   property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait state longer than one cycle");
endmodule

// *** testbench/piolc_pin_model.sv ***
/* Package pins and the two multiplexed peripherals.
   Assumes the bench names which lines an outside device drives. */
`timescale 1ns/1ps
// ****************************************
// Pin model
// ****************************************
module piolc_pin_model #(
   parameter logic [31:0] A_OUT = 32'h0000_4400,
   parameter logic [31:0] A_OE  = 32'h0000_CC00,
   parameter logic [31:0] B_OUT = 32'h0000_1100,
   parameter logic [31:0] B_OE  = 32'h0000_3300
) (
   input  wire logic [31:0] pin_out,
   input  wire logic        clk,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] pullup_on,
   input  wire logic [31:0] ext_en,
   input  wire logic [31:0] ext_val,
   output logic      [31:0] pin_in,
   output logic      [31:0] a_out,
   output logic      [31:0] a_oe,
   output logic      [31:0] b_out,
   output logic      [31:0] b_oe
);
   logic [31:0] flt_reg = 32'h5555_5555;
   // A bare line floats; toggling it keeps a stale level from passing for a real one.
   always @(posedge clk) flt_reg <= ~flt_reg;
   // Released lines read an outside driver where one is on, else high through the pull-up or the toggling float level.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pullup_on | flt_reg));
   assign a_out = A_OUT;
   assign a_oe  = A_OE;
   assign b_out = B_OUT;
   assign b_oe  = B_OE;
endmodule

// *** testbench/test_parallel_io_line_controller.sv ***
/* Self-checking bench for the parallel I/O line controller.
   Assumes the pin model and the checker are compiled before this file. */
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, e, g)
// ****************************************
// Bench
// ****************************************
module test_parallel_io_line_controller import piolc_pkg::*;;
   localparam piolc_word_t MUX_L = 32'h00FF_FFFF;
   localparam piolc_word_t OWN_R = 32'hFFFF_FF00;
   logic        clk = 1'b0;
   logic        rst, clk_enable, avs_read, avs_write, avs_waitrequest, line_irq_in, irq;
   logic [7:0]  avs_address;
   logic [3:0]  avs_byteenable;
   piolc_word_t avs_writedata, avs_readdata, pin_in, pin_out, pin_oe, pullup_on, q, e;
   piolc_word_t pa_out, pa_oe, pb_out, pb_oe, periph_a_in, periph_b_in, ext_en, ext_val;
   int          fail_count = 0;
   int          n_compared = 0;
   logic [7:0]  tset [7] = '{8'h00, 8'h10, 8'h30, 8'h50, 8'h74, 8'hA0, 8'h60};
   logic [7:0]  tclr [7] = '{8'h04, 8'h14, 8'h34, 8'h54, 8'h70, 8'hA4, 8'h64};
   logic [7:0]  tst  [7] = '{8'h08, 8'h18, 8'h38, 8'h58, 8'h78, 8'hA8, 8'h68};
   logic [39:0] cfg  [14] = '{{8'h00, 32'hFFFF_FFFF}, {8'h14, 32'hFFFF_FFFF},
      {8'h10, 32'h0000_00FF}, {8'h34, 32'hFFFF_FFFF}, {8'h30, 32'h0000_00A5},
      {8'h54, 32'hFFFF_FFFF}, {8'h50, 32'h0000_000F}, {8'h64, 32'hFFFF_FFFF},
      {8'h70, 32'h0000_0F00}, {8'h74, 32'h0000_F000}, {8'h04, 32'h0000_FF00},
      {8'h10, 32'h0000_FF00}, {8'h30, 32'h0000_FF00}, {8'h00, 32'h0000_FF00}};
   always #2.5 clk = ~clk;
   piolc_top #(.MUX_LINES(MUX_L), .OWN_RESET(OWN_R)) piolc_top_inst (
      .clk(clk), .rst(rst), .clk_enable(clk_enable), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .pin_in(pin_in),
      .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pullup_on), .periph_a_out(pa_out), .periph_a_oe(pa_oe), .periph_b_out(pb_out),
      .periph_b_oe(pb_oe), .periph_a_in(periph_a_in), .periph_b_in(periph_b_in),
      .line_irq_in(line_irq_in), .irq(irq));
   piolc_pin_model piolc_pin_model_inst (
      .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in), .a_out(pa_out), .a_oe(pa_oe), .b_out(pb_out),
      .b_oe(pb_oe));
   task automatic check(input string nm, input piolc_word_t ex, input piolc_word_t got);
      n_compared++;
      if (got !== ex) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Holds the request until waitrequest is sampled low at a rising edge, then releases it.
   task automatic acc(input logic w, input logic [7:0] a, input piolc_word_t d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 40) `CHK("waitrequest", 32'h0000_0000, 32'h0000_0001);
   endtask
   task automatic rdc(input logic [7:0] a, input piolc_word_t ex, input string nm);
      acc(1'b0, a, 32'h0000_0000);
      `CHK(nm, ex, q);
   endtask
   task automatic run(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) acc(1'b1, cfg[i][39:32], cfg[i][31:0]);
      @(negedge clk);
   endtask
   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      clk_enable = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      line_irq_in = 1'b0;
      ext_en = 32'hFFFF_FF00;
      ext_val = 32'h1234_5600;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) rdc(tst[i], (i == 0) ? OWN_R : 32'h0000_0000, "rst");
      rdc(8'h0C, 32'h0000_0000, "unmapped");
      $display("test reset finished");
      // Clock stays off here: configuration must not depend on it.
      for (int i = 0; i < 7; i++) begin
         e = ((i == 0) ? OWN_R : 32'h0000_0000) | 32'hA5A5_A5A5;
         acc(1'b1, tset[i], 32'hA5A5_A5A5);
         rdc(tst[i], (i == 0) ? (e | ~MUX_L) : e, "set");
         e = e & ~32'h0F0F_00FF;
         acc(1'b1, tclr[i], 32'h0F0F_00FF);
         rdc(tst[i], (i == 0) ? (e | ~MUX_L) : e, "clear");
      end
      `CHK("pullup_on", 32'h5F5F_5AFF, pullup_on);
      acc(1'b1, 8'h30, 32'h0000_00FF);
      acc(1'b1, 8'h38, 32'h1234_5678);
      rdc(8'h38, 32'h0000_00FF | (32'h1234_5678 & 32'hA0A0_A500), "sync");
      $display("test triplets finished");
      clk_enable <= 1'b1;
      line_irq_in <= 1'b1;
      run(0, 7);
      `CHK("oe", 32'h0000_00FA, pin_oe);
      `CHK("od", 32'h0000_0000, pin_out & pin_oe & 32'h0000_000F);
      `CHK("irq", 32'h0000_0001, {31'h0000_0000, irq});
      rdc(8'h3C, 32'h1234_56A5, "pin");
      clk_enable <= 1'b0;
      ext_val <= 32'h0000_0000;
      repeat (3) @(posedge clk);
      rdc(8'h3C, 32'h1234_56A5, "pinhold");
      `CHK("irqoff", 32'h0000_0000, {31'h0000_0000, irq});
      $display("test pins finished");
      run(8, 10);
      `CHK("poe", 32'h0000_3C00, pin_oe & 32'h0000_FF00);
      `CHK("pout", 32'h0000_1400, pin_out & pin_oe & 32'h0000_FF00);
      run(11, 13);
      `CHK("preoe", 32'h0000_FF00, pin_oe & 32'h0000_FF00);
      `CHK("preout", 32'h0000_FF00, pin_out & 32'h0000_FF00);
      $display("test handoff finished");
      complete_run();
   end
endmodule
bind piolc_top piolc_checker piolc_checker_inst (
   .clk(clk), .rst(rst), .clk_enable(clk_enable), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
   .pullup_on(pullup_on), .periph_a_in(periph_a_in), .periph_b_in(periph_b_in),
   .line_irq_in(line_irq_in), .irq(irq));
